/* File: aoc_output_config.v */
// output configuration register bank and output sample selection
`timescale 1ns/1ps
`include "aoc_regs.vh"
module aoc_output_config #(
  parameter WORD_W = 11
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // serial programming pins
  input wire ser_enable_n,
  input wire ser_clk,
  input wire ser_data,
  // device controls from outside this bank
  input wire format_select_pin,
  input wire [2:0] test_pattern_select,
  // converted samples, offset binary
  input wire [WORD_W-1:0] sample_in,
  // configuration outputs
  output reg clock_out_drive_double_q,
  output reg data_drive_double_q,
  output reg twos_complement_q,
  output reg offset_loop_enable_q,
  output reg noise_shaping_enable_q,
  output reg [3:0] noise_shaping_coef_one_q,
  output reg [3:0] noise_shaping_coef_two_q,
  // output data
  output reg [WORD_W-1:0] data_out_q
);

  // ----------------------------------------
  // serial receiver
  // ----------------------------------------
  wire wr_stb;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  reg [1:0] fmt_q;
  reg [7:0] pat_upper_q;
  reg [2:0] pat_lower_q;
  reg [1:0] dfs_s_q;
  reg twos_d;
  wire [WORD_W-1:0] custom_word;

  aoc_serial_rx u_rx (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ser_enable_n(ser_enable_n),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .wr_stb_q(wr_stb),
    .wr_addr_q(wr_addr),
    .wr_data_q(wr_data)
  );

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = wr_stb && (addr == target);
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      clock_out_drive_double_q <= 1'b0;
      data_drive_double_q <= 1'b0;
      fmt_q <= `AOC_FMT_PIN; // R08
      offset_loop_enable_q <= 1'b0;
      noise_shaping_enable_q <= 1'b0;
      noise_shaping_coef_one_q <= 4'h0;
      noise_shaping_coef_two_q <= 4'h0;
      pat_upper_q <= `AOC_RESET_VAL;
      pat_lower_q <= 3'h0;
    end else begin
      if (hit(wr_addr, `AOC_ADDR_DRIVE)) begin
        clock_out_drive_double_q <= wr_data[`AOC_BIT_CLK_DRIVE]; // R01
        data_drive_double_q <= wr_data[`AOC_BIT_DATA_DRIVE]; // R02
      end
      if (hit(wr_addr, `AOC_ADDR_FORMAT)) begin
        fmt_q <= wr_data[`AOC_FMT_HI:`AOC_FMT_LO]; // R03
        offset_loop_enable_q <= wr_data[`AOC_BIT_OFFSET_EN]; // R04
        noise_shaping_enable_q <= wr_data[`AOC_BIT_NS_EN]; // R11
        noise_shaping_coef_one_q <= wr_data[`AOC_COEF1_HI:`AOC_COEF1_LO]; // R11
      end
      if (hit(wr_addr, `AOC_ADDR_COEF_TWO)) begin
        // low bits are reserved and expected zero from the host
        noise_shaping_coef_two_q <= wr_data[`AOC_COEF2_HI:`AOC_COEF2_LO]; // R05 R06
      end
      if (hit(wr_addr, `AOC_ADDR_PAT_UPPER)) begin
        pat_upper_q <= wr_data; // R07
      end
      if (hit(wr_addr, `AOC_ADDR_PAT_LOWER)) begin
        pat_lower_q <= wr_data[`AOC_PATLO_HI:`AOC_PATLO_LO]; // R07 R10
      end
    end
  end

  // ----------------------------------------
  // format selection
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      dfs_s_q <= 2'h0;
    end else begin
      dfs_s_q <= {dfs_s_q[0], format_select_pin};
    end
  end

  always @* begin
    case (fmt_q)
      `AOC_FMT_TWOS: twos_d = 1'b1; // R03
      `AOC_FMT_OFFSET: twos_d = 1'b0; // R03
      default: twos_d = dfs_s_q[1]; // R03
    endcase
  end

  // ----------------------------------------
  // output data
  // ----------------------------------------
  assign custom_word = {pat_upper_q, pat_lower_q}; // R07

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      twos_complement_q <= 1'b0;
      data_out_q <= {WORD_W{1'b0}};
    end else begin
      twos_complement_q <= twos_d;
      if (test_pattern_select == `AOC_TP_CUSTOM) begin
        data_out_q <= custom_word; // R09
      end else if (twos_d) begin
        data_out_q <= {~sample_in[WORD_W-1], sample_in[WORD_W-2:0]};
      end else begin
        data_out_q <= sample_in;
      end
    end
  end

endmodule // aoc_output_config

/* File: aoc_regs.vh */
// register map, field positions and reset values of the output configuration bank
// How it works
// R01 - clock drive bit: 0 normal, 1 double
// R02 - data drive bit sets all data buffers
// R03 - format field: 00 pin, 10 twos, 11 offset
// R04 - offset loop enable bit switches correction loop
// R05 - second coefficient in upper four bits
// R06 - host writes zero to low four bits
// R07 - custom word split D10-D3 and D2-D0
// R08 - format, enhancement, pattern registers reset zero
// R09 - pattern code 101 outputs custom word
// R10 - host writes zero to low five bits
// R11 - enhancement enable bit 4, coefficient one bits 3-0
`ifndef AOC_REGS_VH
`define AOC_REGS_VH

// ----------------------------------------
// offsets
// ----------------------------------------
`define AOC_ADDR_DRIVE 8'h26
`define AOC_ADDR_FORMAT 8'h3d
`define AOC_ADDR_COEF_TWO 8'h3e
`define AOC_ADDR_PAT_UPPER 8'h3f
`define AOC_ADDR_PAT_LOWER 8'h40

// ----------------------------------------
// fields
// ----------------------------------------
`define AOC_BIT_CLK_DRIVE 1
`define AOC_BIT_DATA_DRIVE 0
`define AOC_FMT_HI 7
`define AOC_FMT_LO 6
`define AOC_BIT_OFFSET_EN 5
`define AOC_BIT_NS_EN 4
`define AOC_COEF1_HI 3
`define AOC_COEF1_LO 0
`define AOC_COEF2_HI 7
`define AOC_COEF2_LO 4
`define AOC_PATLO_HI 7
`define AOC_PATLO_LO 5

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define AOC_FMT_PIN 2'h0
`define AOC_FMT_TWOS 2'h2
`define AOC_FMT_OFFSET 2'h3
`define AOC_TP_CUSTOM 3'h5
`define AOC_RESET_VAL 8'h00
`define AOC_SER_BITS 16
`define AOC_SER_LAST 5'h0f

`endif

/* File: aoc_serial_rx.v */
// serial programming receiver: 8 address bits then 8 data bits, msb first
`timescale 1ns/1ps
`include "aoc_regs.vh"
module aoc_serial_rx (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // serial pins
  input wire ser_enable_n,
  input wire ser_clk,
  input wire ser_data,
  // decoded write
  output reg wr_stb_q,
  output reg [7:0] wr_addr_q,
  output reg [7:0] wr_data_q
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] sen_s_q;
  reg [2:0] sclk_s_q;
  reg [1:0] sdat_s_q;
  reg [15:0] shift_q;
  reg [4:0] count_q;
  wire sclk_rise;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sen_s_q <= 2'h3;
      sclk_s_q <= 3'h0;
      sdat_s_q <= 2'h0;
    end else begin
      sen_s_q <= {sen_s_q[0], ser_enable_n};
      sclk_s_q <= {sclk_s_q[1:0], ser_clk};
      sdat_s_q <= {sdat_s_q[0], ser_data};
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];

  // ----------------------------------------
  // shift and word assembly
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (sen_s_q[1]) begin
        // frame ended or idle: a partial word is dropped
        count_q <= 5'h00;
      end else if (sclk_rise) begin
        shift_q <= {shift_q[14:0], sdat_s_q[1]};
        if (count_q == `AOC_SER_LAST) begin
          count_q <= 5'h00;
          wr_stb_q <= 1'b1;
          wr_addr_q <= shift_q[14:7];
          wr_data_q <= {shift_q[6:0], sdat_s_q[1]};
        end else begin
          count_q <= count_q + 5'h01;
        end
      end
    end
  end

endmodule // aoc_serial_rx

/* File: aoc_output_config_assertions.sv */
// port assertions for the output configuration bank
`timescale 1ns/1ps
module aoc_checker #(
  parameter WORD_W = 11
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // inputs
  input wire ser_enable_n,
  input wire ser_clk,
  input wire ser_data,
  input wire format_select_pin,
  input wire [2:0] test_pattern_select,
  input wire [WORD_W-1:0] sample_in,
  // outputs
  input wire clock_out_drive_double_q,
  input wire data_drive_double_q,
  input wire twos_complement_q,
  input wire offset_loop_enable_q,
  input wire noise_shaping_enable_q,
  input wire [3:0] noise_shaping_coef_one_q,
  input wire [3:0] noise_shaping_coef_two_q,
  input wire [WORD_W-1:0] data_out_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_reset_clk_drive: assert property ($fell(sys_rst) |-> !clock_out_drive_double_q)
    else $error("clock drive not cleared by reset");
  a_reset_data_drive: assert property ($fell(sys_rst) |-> !data_drive_double_q)
    else $error("data drive not cleared by reset");
  a_reset_offset: assert property ($fell(sys_rst) |-> !offset_loop_enable_q)
    else $error("offset loop not cleared by reset");
  a_reset_coef_two: assert property ($fell(sys_rst) |-> noise_shaping_coef_two_q == 4'h0)
    else $error("coefficient two not cleared by reset");
  a_reset_shaping: assert property ($fell(sys_rst) |->
    !noise_shaping_enable_q && noise_shaping_coef_one_q == 4'h0)
    else $error("shaping fields not cleared by reset");
  a_reset_word: assert property ($fell(sys_rst) |-> data_out_q == '0)
    else $error("output word not cleared by reset");
  a_plain_sample: assert property (test_pattern_select == 3'h0
    |=> data_out_q == ($past(sample_in) ^ {twos_complement_q, {(WORD_W-1){1'b0}}}))
    else $error("sample format wrong");
  a_custom_hold: assert property ((test_pattern_select == 3'h5 && ser_enable_n)[*8]
    |=> $stable(data_out_q))
    else $error("custom word not held");
endmodule // aoc_checker

bind aoc_output_config aoc_checker #(.WORD_W(WORD_W)) i_chk (.clk_sys, .sys_rst, .ser_enable_n,
  .ser_clk, .ser_data, .format_select_pin, .test_pattern_select, .sample_in,
  .clock_out_drive_double_q, .data_drive_double_q, .twos_complement_q, .offset_loop_enable_q,
  .noise_shaping_enable_q, .noise_shaping_coef_one_q, .noise_shaping_coef_two_q, .data_out_q);

/* File: aoc_host_model.sv */
// serial programming host writing address and data words
`timescale 1ns/1ps
module aoc_host_model (
  // serial pins
  output logic ser_enable_n,
  output logic ser_clk,
  output logic ser_data
);
  initial begin
    ser_enable_n = 1'b1;
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end
  task automatic write_word(input logic [15:0] w, input int n);
    if (w[15:8] == 8'h3e) w[3:0] = 4'h0;
    if (w[15:8] == 8'h40) w[4:0] = 5'h00;
    ser_enable_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      ser_data = w[i];
      #40 ser_clk = 1'b1;
      #40 ser_clk = 1'b0;
    end
    #40 ser_enable_n = 1'b1;
    // released line must not keep the last bit
    ser_data = ~ser_data;
  endtask
endmodule // aoc_host_model

/* File: testbench.sv */
// self-checking bench for the output configuration bank
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic format_select_pin = 1'b1;
  logic [2:0] test_pattern_select = 3'h0;
  logic [10:0] sample_in = 11'h000;
  wire ser_enable_n, ser_clk, ser_data;
  wire clock_out_drive_double_q, data_drive_double_q, twos_complement_q;
  wire offset_loop_enable_q, noise_shaping_enable_q;
  wire [3:0] noise_shaping_coef_one_q, noise_shaping_coef_two_q;
  wire [10:0] data_out_q;
  wire [12:0] cfg = {clock_out_drive_double_q, data_drive_double_q, twos_complement_q,
    offset_loop_enable_q, noise_shaping_enable_q, noise_shaping_coef_one_q,
    noise_shaping_coef_two_q};
  int miscompares = 0;
  int compares = 0;
  // address, data, expected configuration
  logic [28:0] rows [9] = '{{8'h26, 8'h02, 13'h1400}, {8'h26, 8'h01, 13'h0c00},
    {8'h3d, 8'hc0, 13'h0800}, {8'h3d, 8'h80, 13'h0c00}, {8'h3d, 8'h3a, 13'h0fa0},
    {8'h3e, 8'h5f, 13'h0fa5}, {8'h55, 8'hff, 13'h0fa5}, {8'h3f, 8'ha5, 13'h0fa5},
    {8'h40, 8'he0, 13'h0fa5}};
  aoc_host_model i_host (.ser_enable_n, .ser_clk, .ser_data);
  aoc_output_config i_dut (.clk_sys, .sys_rst, .ser_enable_n, .ser_clk, .ser_data,
    .format_select_pin, .test_pattern_select, .sample_in, .clock_out_drive_double_q,
    .data_drive_double_q, .twos_complement_q, .offset_loop_enable_q, .noise_shaping_enable_q,
    .noise_shaping_coef_one_q, .noise_shaping_coef_two_q, .data_out_q);
  always #5 clk_sys = ~clk_sys;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      i_host.write_word(rows[i][28:13], 16);
      repeat (10) @(negedge clk_sys);
      check(cfg, rows[i][12:0]);
      $display("row %0d done", i);
    end
    // a frame cut after eight bits must leave every register alone
    i_host.write_word(16'h3dc0, 8);
    repeat (10) @(negedge clk_sys);
    check(cfg, 13'h0fa5);
    $display("partial frame done");
    test_pattern_select = 3'h5;
    sample_in = 11'h3c3;
    repeat (12) begin
      @(negedge clk_sys);
      sample_in = ~sample_in;
    end
    check(data_out_q, 11'h52f);
    test_pattern_select = 3'h0;
    repeat (2) @(negedge clk_sys);
    check(data_out_q, 11'h7c3);
    format_select_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    check({twos_complement_q, data_out_q}, 12'h3c3);
    format_select_pin = 1'b1;
    $display("data path done");
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({cfg, data_out_q}, 24'h0);
    sys_rst = 1'b0;
    test_pattern_select = 3'h5;
    repeat (6) @(negedge clk_sys);
    check({twos_complement_q, data_out_q}, 12'h800);
    $display("reset done");
    summarize();
  end
endmodule // testbench
